// File: rtl/ext_diag.sv
// Extended diagnosis report and fault handling of a linear absolute encoder
`timescale 1ns/1ps
`include "ext_diag_consts.svh"
module ext_diag #(
  parameter longint unsigned TICK_CYC  = 64'(`CLK_HZ) * `HOUR_TICK_MIN * `SEC_PER_MIN,
  // Identity values below are arbitrary
  parameter logic [15:0]     MAKER_ID  = 16'h5A3C,
  parameter logic [7:0]      TYPE_CODE = 8'h5C,
  parameter logic [15:0]     PROF_REV  = 16'h0A0B,
  parameter logic [15:0]     FW_REV    = 16'h0C0D
) (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     nrst_i,
  // Fault sources
  input  wire logic                     magnet_lost_i,
  input  wire logic                     supply_fault_i,
  input  wire logic                     overcurrent_i,
  input  wire logic                     selftest_fail_i,
  input  wire logic                     memory_fault_i,
  // Configuration
  input  wire logic                     count_down_i,
  input  wire logic                     scaling_on_i,
  input  wire logic                     maker_cfg_i,
  input  wire logic                     hours_en_i,
  input  wire logic                     serial_ok_i,
  input  wire ext_diag_pkg::diag_word_t step_nm_i,
  input  wire ext_diag_pkg::diag_word_t meas_len_i,
  input  wire ext_diag_pkg::serial_t    serial_i,
  input  wire ext_diag_pkg::diag_byte_t master_addr_i,
  input  wire logic                     prm_done_i,
  // Preset
  input  wire logic                     preset_i,
  input  wire ext_diag_pkg::diag_word_t preset_val_i,
  input  wire ext_diag_pkg::diag_word_t maker_offs_i,
  // Position path
  input  wire ext_diag_pkg::diag_word_t pos_i,
  input  wire logic                     pos_valid_i,
  output      ext_diag_pkg::diag_word_t pos_o,
  output      logic                     pos_valid_o,
  // Diagnosis read port
  input  wire logic                     diag_rd_i,
  input  wire ext_diag_pkg::diag_idx_t  diag_idx_i,
  input  wire logic                     diag_done_i,
  output      ext_diag_pkg::diag_byte_t diag_rdata_o,
  output      logic                     ext_diag_o,
  output      logic                     stat_diag_o
);
  import ext_diag_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  alarm_vec_t alarm_q;
  alarm_vec_t alarm_d;
  logic       ext_pend_q;
  logic       ext_pend_d;
  logic       stat_q;
  logic       stat_d;
  diag_word_t hours_snap_q;
  diag_word_t hours_snap_d;
  diag_word_t offs_q;
  diag_word_t offs_d;
  diag_word_t moffs_q;
  diag_word_t moffs_d;
  diag_word_t pos_q;
  diag_word_t pos_d;
  logic       pos_valid_q;
  logic       pos_valid_d;
  diag_byte_t rdata_q;
  diag_byte_t rdata_d;

  wire diag_word_t hours_live_w;

  // ----------------------------------------------------------------
  // Operating time counter
  // ----------------------------------------------------------------
  run_time_meter #(
    .TICK_CYC (TICK_CYC)
  ) u_meter (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .count_o (hours_live_w)
  );

  // ----------------------------------------------------------------
  // Fault tracking
  // ----------------------------------------------------------------
  wire alarm_vec_t alarm_in_w;
  wire logic       fault_w;
  wire logic       new_alarm_w;
  wire logic       report_evt_w;

  // Live fault inputs; none can be acknowledged by a bus command
  assign alarm_in_w   = {memory_fault_i, selftest_fail_i, overcurrent_i,
                         supply_fault_i, magnet_lost_i};
  assign alarm_d      = alarm_in_w;
  assign fault_w      = |alarm_in_w;
  assign new_alarm_w  = |(alarm_in_w & ~alarm_q);
  // Only parameterization or a new error raises a fresh report
  assign report_evt_w = prm_done_i | new_alarm_w;

  // Pending stays while a fault is present; a new event beats the ack
  assign ext_pend_d   = report_evt_w | fault_w |
                        (ext_pend_q & ~diag_done_i);
  assign stat_d       = fault_w;

  // ----------------------------------------------------------------
  // Snapshots
  // ----------------------------------------------------------------
  assign hours_snap_d = report_evt_w ? hours_live_w : hours_snap_q;
  assign offs_d       = preset_i ? preset_val_i - pos_i : offs_q;
  assign moffs_d      = preset_i ? maker_offs_i : moffs_q;

  // ----------------------------------------------------------------
  // Position gating
  // ----------------------------------------------------------------
  assign pos_valid_d  = pos_valid_i & ~fault_w & ~stat_q;
  assign pos_d        = pos_valid_d ? pos_i : pos_q;

  // ----------------------------------------------------------------
  // Report fields
  // ----------------------------------------------------------------
  wire diag_byte_t stn1_w;
  wire diag_byte_t stn2_w;
  wire diag_byte_t stn3_w;
  wire diag_byte_t alarm_byte_w;
  wire diag_byte_t opstat_w;
  wire diag_word_t hours_field_w;
  wire serial_t    serial_field_w;

  generate
    for (genvar i = 0; i < 8; i++) begin : g_stn
      if (i == `STN1_EXT_DIAG_BIT) begin : g_ext
        assign stn1_w[i] = ext_pend_q;
      end else begin : g_zero
        assign stn1_w[i] = 1'b0;
      end
      if (i == `STN2_STAT_DIAG_BIT) begin : g_stat
        assign stn2_w[i] = stat_q;
      end else if (i == `STN2_SLAVE_BIT) begin : g_slv
        assign stn2_w[i] = 1'b1;
      end else begin : g_zero2
        assign stn2_w[i] = 1'b0;
      end
    end
  endgenerate
  assign stn3_w = 8'h00;

  // Unused alarm bits read zero
  assign alarm_byte_w = {{(8 - `ALARM_NUM){1'b0}}, alarm_q};

  generate
    for (genvar b = 0; b < 8; b++) begin : g_op
      if (b == `OPSTAT_DIR_BIT) begin : g_dir
        assign opstat_w[b] = count_down_i;
      end else if (b == `OPSTAT_CLS2_BIT) begin : g_cls
        assign opstat_w[b] = 1'b1;
      end else if (b == `OPSTAT_DIAG_BIT) begin : g_dg
        assign opstat_w[b] = 1'b1;
      end else if (b == `OPSTAT_SCALE_BIT) begin : g_sc
        assign opstat_w[b] = scaling_on_i;
      end else if (b == `OPSTAT_CFG_BIT) begin : g_cfg
        assign opstat_w[b] = maker_cfg_i;
      end else begin : g_unused
        assign opstat_w[b] = 1'b0;
      end
    end
  endgenerate

  assign hours_field_w  = hours_en_i ? hours_snap_q
                                     : `HOURS_UNSUPPORTED;
  assign serial_field_w = serial_ok_i ? serial_i
                                      : {`SERIAL_BYTES{`SERIAL_FILL}};

  // ----------------------------------------------------------------
  // Register view
  // ----------------------------------------------------------------
  // One named word per report register
  wire diag_byte_t  alarm_flags_w;
  wire diag_byte_t  operating_state_flags_w;
  wire diag_byte_t  device_type_code_w;
  wire diag_word_t  step_size_nm_w;
  wire logic [15:0] turn_count_fixed_w;
  wire diag_byte_t  extra_alarm_flags_w;
  wire logic [15:0] alarm_support_mask_w;
  wire logic [15:0] warning_flags_w;
  wire logic [15:0] warning_support_mask_w;
  wire logic [15:0] profile_revision_w;
  wire logic [15:0] firmware_revision_w;
  wire diag_word_t  run_time_counter_w;
  wire diag_word_t  preset_offset_w;
  wire diag_word_t  maker_preset_offset_w;
  wire diag_word_t  steps_per_turn_w;
  wire diag_word_t  measuring_range_steps_w;
  wire serial_t     unit_serial_w;

  // Live fields and device type code
  assign alarm_flags_w           = alarm_byte_w;
  assign operating_state_flags_w = opstat_w;
  assign device_type_code_w      = TYPE_CODE;
  assign step_size_nm_w          = step_nm_i;

  // Fixed, reserved and default fields
  assign turn_count_fixed_w      = `TURN_FIXED;
  assign extra_alarm_flags_w     = `XALARM_DEFAULT;
  assign alarm_support_mask_w    = `ALARM_SUPPORTED;
  assign warning_flags_w         = `WARN_DEFAULT;
  assign warning_support_mask_w  = `WARN_SUPP_DEFAULT;
  assign profile_revision_w      = PROF_REV;
  assign firmware_revision_w     = FW_REV;

  // Snapshots, configured length and serial number
  assign run_time_counter_w      = hours_field_w;
  assign preset_offset_w         = offs_q;
  assign maker_preset_offset_w   = moffs_q;
  assign steps_per_turn_w        = meas_len_i;
  assign measuring_range_steps_w = meas_len_i;
  assign unit_serial_w           = serial_field_w;

  // ----------------------------------------------------------------
  // Report image, byte 0 first, multi-byte fields high byte first
  // ----------------------------------------------------------------
  wire logic [8*`DIAG_IMG_BYTES-1:0] img_w;

  assign img_w = {
    8'h00,                 // byte 0 unused
    stn1_w,                // byte 1
    stn2_w,                // byte 2
    stn3_w,                // byte 3
    master_addr_i,         // byte 4
    MAKER_ID,              // bytes 5-6
    `EXT_DIAG_LEN,         // byte 7
    alarm_flags_w,           // byte 8
    operating_state_flags_w, // byte 9
    device_type_code_w,      // byte 10
    step_size_nm_w,          // bytes 11-14
    turn_count_fixed_w,      // bytes 15-16
    extra_alarm_flags_w,     // byte 17
    alarm_support_mask_w,    // bytes 18-19
    warning_flags_w,         // bytes 20-21
    warning_support_mask_w,  // bytes 22-23
    profile_revision_w,      // bytes 24-25
    firmware_revision_w,     // bytes 26-27
    run_time_counter_w,      // bytes 28-31
    preset_offset_w,         // bytes 32-35
    maker_preset_offset_w,   // bytes 36-39
    steps_per_turn_w,        // bytes 40-43
    measuring_range_steps_w, // bytes 44-47
    unit_serial_w            // bytes 48-57
  };

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  wire logic       idx_ok_w;
  wire logic [5:0] idx_rev_w;
  wire diag_byte_t sel_w;

  assign idx_ok_w  = (diag_idx_i <= `DIAG_LAST_IDX);
  // Image holds byte 0 in its top bits
  assign idx_rev_w = `DIAG_LAST_IDX - diag_idx_i;
  // Beyond the report everything reads zero
  assign sel_w     = idx_ok_w ? img_w[{idx_rev_w, 3'b000} +: 8] : 8'h00;
  assign rdata_d   = diag_rd_i ? sel_w : rdata_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      alarm_q      <= 5'h00;
      ext_pend_q   <= 1'b0;
      stat_q       <= 1'b0;
      hours_snap_q <= 32'h0;
    end else begin
      alarm_q      <= alarm_d;
      ext_pend_q   <= ext_pend_d;
      stat_q       <= stat_d;
      hours_snap_q <= hours_snap_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      offs_q  <= 32'h0;
      moffs_q <= 32'h0;
    end else begin
      offs_q  <= offs_d;
      moffs_q <= moffs_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pos_q       <= 32'h0;
      pos_valid_q <= 1'b0;
      rdata_q     <= 8'h00;
    end else begin
      pos_q       <= pos_d;
      pos_valid_q <= pos_valid_d;
      rdata_q     <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pos_o        = pos_q;
  assign pos_valid_o  = pos_valid_q;
  assign diag_rdata_o = rdata_q;
  assign ext_diag_o   = ext_pend_q;
  assign stat_diag_o  = stat_q;
endmodule

// File: rtl/ext_diag_consts.svh
// Constants for the extended diagnosis report: byte indices, bits, defaults, timing
`ifndef EXT_DIAG_CONSTS_SVH
`define EXT_DIAG_CONSTS_SVH

// ----------------------------------------------------------------
// Report layout
// ----------------------------------------------------------------
`define DIAG_LAST_IDX      6'h39
`define DIAG_IMG_BYTES     58
`define STN1_IDX           6'h01
`define STN2_IDX           6'h02
`define LEN_IDX            6'h07
`define ALARM_IDX          6'h08
`define OPSTAT_IDX         6'h09
`define TYPE_IDX           6'h0A
`define STEP_IDX           6'h0B
`define TURN_IDX           6'h0F
`define XALARM_IDX         6'h11
`define ASUPP_IDX          6'h12
`define WARN_IDX           6'h14
`define WSUPP_IDX          6'h16
`define PROF_IDX           6'h18
`define FW_IDX             6'h1A
`define HOURS_IDX          6'h1C
`define OFFS_IDX           6'h20
`define MOFFS_IDX          6'h24
`define STEPS_TURN_IDX     6'h28
`define RANGE_IDX          6'h2C
`define SERIAL_IDX         6'h30

// ----------------------------------------------------------------
// Field bits and fixed values
// ----------------------------------------------------------------
`define STN1_EXT_DIAG_BIT  3
`define STN2_STAT_DIAG_BIT 1
`define STN2_SLAVE_BIT     2
`define ALARM_POS_BIT      0
`define ALARM_NUM          5
`define OPSTAT_DIR_BIT     0
`define OPSTAT_CLS2_BIT    1
`define OPSTAT_DIAG_BIT    2
`define OPSTAT_SCALE_BIT   3
`define OPSTAT_CFG_BIT     7
`define EXT_DIAG_LEN       8'h33
`define TURN_FIXED         16'h0001
`define XALARM_DEFAULT     8'h00
`define ALARM_SUPPORTED    16'h0001
`define WARN_DEFAULT       16'h0000
`define WARN_SUPP_DEFAULT  16'h0000
`define HOURS_UNSUPPORTED  32'h0FFFFFFF
`define SERIAL_FILL        8'h2A
`define SERIAL_BYTES       10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ             50000000
`define HOUR_TICK_MIN      6
`define SEC_PER_MIN        60

`endif

// File: rtl/ext_diag_pkg.sv
// Types shared by the extended diagnosis report logic
package ext_diag_pkg;
  typedef logic [7:0]  diag_byte_t;
  typedef logic [5:0]  diag_idx_t;
  typedef logic [31:0] diag_word_t;
  typedef logic [79:0] serial_t;
  typedef logic [4:0]  alarm_vec_t;
endpackage

// File: rtl/run_time_meter.sv
// Operating time counter in tenths of an hour
`timescale 1ns/1ps
`include "ext_diag_consts.svh"
module run_time_meter #(
  parameter longint unsigned TICK_CYC = 64'(`CLK_HZ) * `HOUR_TICK_MIN * `SEC_PER_MIN
) (
  // Clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    nrst_i,
  // Count
  output      ext_diag_pkg::diag_word_t count_o
);
  import ext_diag_pkg::*;

  logic [34:0] pre_q;
  logic [34:0] pre_d;
  diag_word_t  cnt_q;
  diag_word_t  cnt_d;
  wire         tick_w;

  // ----------------------------------------------------------------
  // One count per elapsed tick period
  // ----------------------------------------------------------------
  assign tick_w  = (pre_q == 35'(TICK_CYC - 64'd1));
  assign pre_d   = tick_w ? 35'h0 : pre_q + 35'h1;
  assign cnt_d   = tick_w ? cnt_q + 32'h1 : cnt_q;
  assign count_o = cnt_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pre_q <= 35'h0;
      cnt_q <= 32'h0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// File: bench/ext_diag_properties.sv
// Port checker for the extended diagnosis report
`timescale 1ns/1ps
module ext_diag_properties (
  // Clock and reset
  input wire logic                     mclk_i,
  input wire logic                     nrst_i,
  // Stimulus side
  input wire logic                     magnet_lost_i,
  input wire logic                     supply_fault_i,
  input wire logic                     overcurrent_i,
  input wire logic                     selftest_fail_i,
  input wire logic                     memory_fault_i,
  input wire logic                     hours_en_i,
  input wire logic                     prm_done_i,
  input wire logic                     diag_rd_i,
  input wire ext_diag_pkg::diag_idx_t  diag_idx_i,
  input wire logic                     diag_done_i,
  // Device outputs
  input wire ext_diag_pkg::diag_byte_t diag_rdata_o,
  input wire logic                     pos_valid_o,
  input wire logic                     ext_diag_o,
  input wire logic                     stat_diag_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire logic [4:0] flt = {memory_fault_i, selftest_fail_i, overcurrent_i,
                          supply_fault_i, magnet_lost_i};
  property p_stat_on;
    (|flt) |=> stat_diag_o;
  endproperty
  a_stat_on: assert property (p_stat_on) else $error("static fault not raised");
  property p_stat_off;
    !(|flt) |=> !stat_diag_o;
  endproperty
  a_stat_off: assert property (p_stat_off) else $error("static fault stuck");
  property p_pos_block;
    (|flt) |=> !pos_valid_o;
  endproperty
  a_pos_block: assert property (p_pos_block) else $error("position during fault");
  property p_ext_set;
    ((flt & ~$past(flt)) != 5'h00 || prm_done_i) |=> ext_diag_o;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("pending flag not set");
  property p_ext_hold;
    ext_diag_o && (|flt) |=> ext_diag_o;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("pending cleared in fault");
  property p_ext_clr;
    ext_diag_o && diag_done_i && flt == 5'h00 && $past(flt) == 5'h00 && !prm_done_i
      |=> !ext_diag_o;
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("pending not cleared");
  property p_len;
    diag_rd_i && diag_idx_i == 6'h07 |=> diag_rdata_o == 8'h33;
  endproperty
  a_len: assert property (p_len) else $error("length byte wrong");
  property p_turn;
    diag_rd_i && diag_idx_i == 6'h10 |=> diag_rdata_o == 8'h01;
  endproperty
  a_turn: assert property (p_turn) else $error("turn field wrong");
  property p_supp;
    diag_rd_i && diag_idx_i == 6'h13 |=> diag_rdata_o == 8'h01;
  endproperty
  a_supp: assert property (p_supp) else $error("alarm support wrong");
  property p_hours;
    diag_rd_i && diag_idx_i == 6'h1C && !hours_en_i |=> diag_rdata_o == 8'h0F;
  endproperty
  a_hours: assert property (p_hours) else $error("hour field not maximum");
endmodule

bind ext_diag ext_diag_properties chk (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .magnet_lost_i(magnet_lost_i),
  .supply_fault_i(supply_fault_i), .overcurrent_i(overcurrent_i),
  .selftest_fail_i(selftest_fail_i), .memory_fault_i(memory_fault_i),
  .hours_en_i(hours_en_i), .prm_done_i(prm_done_i), .diag_rd_i(diag_rd_i),
  .diag_idx_i(diag_idx_i), .diag_done_i(diag_done_i), .diag_rdata_o(diag_rdata_o),
  .pos_valid_o(pos_valid_o), .ext_diag_o(ext_diag_o), .stat_diag_o(stat_diag_o)
);

// File: bench/diag_master.sv
// Bus master model that fetches and acknowledges the diagnosis report
`timescale 1ns/1ps
module diag_master (
  // Clock
  input  wire logic                     mclk_i,
  // Device side
  input  wire ext_diag_pkg::diag_byte_t diag_rdata_i,
  input  wire logic                     stat_diag_i,
  output      logic                     rd_o,
  output      ext_diag_pkg::diag_idx_t  idx_o,
  output      logic                     done_o,
  output      logic                     in_image_o
);
  import ext_diag_pkg::*;
  // ----------------------------------------------------------------
  // Report fetch
  // ----------------------------------------------------------------
  diag_byte_t img [0:63];
  initial begin
    rd_o = 1'b0;
    idx_o = 6'h2A;
    done_o = 1'b0;
  end
  always_ff @(posedge mclk_i) begin
    in_image_o <= !stat_diag_i;
  end
  task automatic read_all();
    for (int i = 0; i <= 64; i++) begin
      @(posedge mclk_i);
      #1;
      if (i > 0) img[i-1] = diag_rdata_i;
      rd_o = (i < 64);
      if (i < 64) idx_o = i[5:0];
    end
  endtask
  task automatic ack();
    @(posedge mclk_i);
    #1;
    done_o = 1'b1;
    @(posedge mclk_i);
    #1;
    done_o = 1'b0;
  endtask
endmodule

// File: bench/encoder_ext_diag_bench.sv
// Self-checking bench for the extended diagnosis report
`timescale 1ns/1ps
module encoder_ext_diag_bench;
  import ext_diag_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and device
  // ----------------------------------------------------------------
  localparam logic [15:0] MAKER = 16'h5A3C; // Arbitrary
  localparam logic [7:0]  TYPEC = 8'h5C;    // Arbitrary
  localparam logic [15:0] PROF  = 16'h0A0B; // Arbitrary
  localparam logic [15:0] FWREV = 16'h0C0D; // Arbitrary
  logic       mclk = 1'b0, nrst = 1'b0, prm = 1'b0, pre = 1'b0, pv = 1'b1;
  logic       hen = 1'b0, sok = 1'b0, pvo, ext, stat, rd, done, in_img;
  logic [4:0] flt = 5'h00;
  logic [2:0] cfg = 3'h0;
  diag_word_t step = '0, len = '0, pval = '0, moff = '0, pos = '0, offs = '0;
  diag_word_t st = 32'h35, pos_q;
  serial_t    ser = '0;
  diag_byte_t addr = '0, rdat;
  diag_idx_t  idx;
  int         n_mismatch = 0, n_checks = 0, cyc = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc++;
  ext_diag #(.TICK_CYC(4), .MAKER_ID(MAKER), .TYPE_CODE(TYPEC), .PROF_REV(PROF),
             .FW_REV(FWREV)) dut (
    .mclk_i(mclk), .nrst_i(nrst), .magnet_lost_i(flt[0]), .supply_fault_i(flt[1]),
    .overcurrent_i(flt[2]), .selftest_fail_i(flt[3]), .memory_fault_i(flt[4]),
    .count_down_i(cfg[0]), .scaling_on_i(cfg[1]), .maker_cfg_i(cfg[2]), .hours_en_i(hen),
    .serial_ok_i(sok), .step_nm_i(step), .meas_len_i(len), .serial_i(ser),
    .master_addr_i(addr), .prm_done_i(prm), .preset_i(pre), .preset_val_i(pval),
    .maker_offs_i(moff), .pos_i(pos), .pos_valid_i(pv), .pos_o(pos_q), .pos_valid_o(pvo),
    .diag_rd_i(rd), .diag_idx_i(idx), .diag_done_i(done), .diag_rdata_o(rdat),
    .ext_diag_o(ext), .stat_diag_o(stat));
  diag_master m (.mclk_i(mclk), .diag_rdata_i(rdat), .stat_diag_i(stat), .rd_o(rd),
                 .idx_o(idx), .done_o(done), .in_image_o(in_img));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic diag_word_t xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  function automatic diag_word_t w32(int a);
    return {m.img[a], m.img[a+1], m.img[a+2], m.img[a+3]};
  endfunction
  // Bytes 4 to 57, hours left as zero
  function automatic logic [431:0] exp_img();
    return {addr, MAKER, 8'h33, 3'b000, flt, 8'h00, TYPEC, step, 16'h0001, 8'h00,
            16'h0001, 32'h0, PROF, FWREV, 32'h0, offs, moff, len, len,
            sok ? ser : {10{8'h2A}}};
  endfunction
  task automatic chk(string what, diag_word_t seen, diag_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    logic [431:0] e;
    diag_word_t   r, d, x;
    int           c1, c2;
    tick(4);
    chk("stat in reset", stat, 0);
    chk("ext in reset", ext, 0);
    nrst = 1'b1;
    for (int k = 0; k < 3; k++) begin
      x = xs();
      cfg = x[2:0];
      sok = x[3];
      step = xs();
      len = xs();
      ser = {xs(), xs(), st[15:0]};
      addr = st[7:0];
      pos = xs();
      pval = xs();
      moff = xs();
      offs = pval - pos;
      pre = 1'b1;
      tick(1);
      pre = 1'b0;
      prm = 1'b1;
      tick(1);
      prm = 1'b0;
      chk("ext after prm", ext, 1);
      m.ack();
      chk("ext after ack", ext, 0);
      m.read_all();
      e = exp_img();
      for (int i = 4; i < 9; i++)
        chk("image byte", m.img[i], e[8*(57-i) +: 8]);
      for (int i = 10; i < 28; i++)
        chk("image byte", m.img[i], e[8*(57-i) +: 8]);
      for (int i = 32; i < 58; i++)
        chk("image byte", m.img[i], e[8*(57-i) +: 8]);
      chk("opstat", m.img[9] & 8'hF9, {cfg[2], 3'b000, cfg[1], 2'b00, cfg[0]});
      chk("stn1 idle", m.img[1], 8'h00);
      chk("stn2 idle", m.img[2], 8'h04);
      chk("hours off", w32(28), 32'h0FFFFFFF);
      for (int i = 58; i < 64; i++) chk("beyond end", m.img[i], 0);
    end
    hen = 1'b1;
    prm = 1'b1;
    c1 = cyc;
    tick(1);
    prm = 1'b0;
    m.read_all();
    r = w32(28);
    tick(300);
    m.read_all();
    chk("hours held", w32(28), r);
    prm = 1'b1;
    c2 = cyc;
    tick(1);
    prm = 1'b0;
    m.read_all();
    d = w32(28) - r;
    chk("hours rate", (d + 1 >= (c2 - c1) / 4) && (d <= (c2 - c1) / 4 + 1), 1);
    for (int b = 0; b < 5; b++) begin
      pos = xs();
      flt[b] = 1'b1;
      tick(2);
      chk("stat on", stat, 1);
      chk("ext on", ext, 1);
      chk("pos blocked", pvo, 0);
      chk("dropped", in_img, 0);
      m.ack();
      chk("ext held", ext, 1);
      m.read_all();
      chk("alarm byte", m.img[8], 8'h01 << b);
      chk("stn1 fault", m.img[1], 8'h08);
      chk("stn2 fault", m.img[2], 8'h06);
      flt[b] = 1'b0;
      tick(3);
      chk("stat off", stat, 0);
      chk("pos back", pvo, 1);
      chk("pos data", pos_q, pos);
      chk("restored", in_img, 1);
      m.ack();
      chk("ext cleared", ext, 0);
    end
    tally_and_finish();
  end
endmodule
